// file: src/qsg_pkg.sv
// Constants shared by the questionable status group block
package qsg_pkg;
    localparam int unsigned        W          = 16;
    localparam int unsigned        AW         = 8;
    localparam int unsigned        NPH        = 3;
    // ----------------------------------------------------------------
    // Register word addresses
    // ----------------------------------------------------------------
    localparam logic [AW-1:0]      A_QCOND    = 8'h00;
    localparam logic [AW-1:0]      A_QEVT     = 8'h01;
    localparam logic [AW-1:0]      A_QEN      = 8'h02;
    localparam logic [AW-1:0]      A_QPTR     = 8'h03;
    localparam logic [AW-1:0]      A_QNTR     = 8'h04;
    localparam logic [AW-1:0]      A_ICOND    = 8'h05;
    localparam logic [AW-1:0]      A_IEVT     = 8'h06;
    localparam logic [AW-1:0]      A_IEN      = 8'h07;
    localparam logic [AW-1:0]      A_IPTR     = 8'h08;
    localparam logic [AW-1:0]      A_INTR     = 8'h09;
    // Per-phase banks: base + phase index 1..3
    localparam logic [AW-1:0]      A_PEVT     = 8'h10;
    localparam logic [AW-1:0]      A_PCOND    = 8'h14;
    localparam logic [AW-1:0]      A_PPTR     = 8'h18;
    localparam logic [AW-1:0]      A_PNTR     = 8'h1c;
    localparam logic [AW-1:0]      A_CMD      = 8'h20;
    // ----------------------------------------------------------------
    // Command register bits and values
    // ----------------------------------------------------------------
    localparam int unsigned        CMD_CLS    = 0;
    localparam int unsigned        CMD_PRESET = 1;
    localparam int unsigned        CMD_RESET  = 2;
    localparam logic [W-1:0]       ZERO       = 16'h0000;
    localparam logic [W-1:0]       ALL_ONES   = 16'hffff;
endpackage

// file: src/qsg_status.sv
// Questionable status, instrument and per-phase summary event groups
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// [R01] Summary bit high while any questionable event bit and its enable bit are set.
// [R02] Masks and filters are plain binary sums and reset to zero.
// [R03] Clear-status zeroes event registers, enables untouched.
// [R04] Negative filter bit one: falling condition bit sets event bit.
// [R05] Positive filter bit one: rising condition bit sets event bit.
// [R06] Both filter bits one: any change sets the event bit.
// [R07] Both filter bits zero: changes never set the event bit.
// [R08] Preset zeroes enables, sets positive filters, zeroes negative filters.
// [R09] Reads return the binary-weighted value of the addressed register.
// [R10] Instrument event register is read-only, latches filtered events, clears on read.
// [R11] Reset command keeps events, but latches events the reset itself causes.
// [R12] Instrument condition register is read-only, live, and unchanged by reads.
// [R13] A condition bit clears as soon as its condition goes away.
// [R14] Reset command clears conditions except those still present afterwards.
// [R15] Instrument enable gates instrument events onto the summary bit.
// [R16] Instrument filters sit between its condition and event registers, same polarity.
// [R17] Three per-phase summary event registers, selected by index one to three.
// [R18] Each per-phase event register is read-only and clears alone when read.
// [R19] Preset loads positive filters with all sixteen bits set.
// [R20] Top-level event register is read-only, latches filtered events, clears on read.
// [R21] All registers are sixteen bits with bits aligned within a group.
module qsg_status (
    input  wire logic                     clock,
    input  wire logic                     rst,
    input  wire logic [qsg_pkg::AW-1:0]   addr,
    input  wire logic [qsg_pkg::W-1:0]    wdata,
    input  wire logic                     wr,
    input  wire logic                     rd,
    output logic      [qsg_pkg::W-1:0]    rdata,
    input  wire logic [qsg_pkg::W-1:0]    questionable_summary_bit_cond_in,
    input  wire logic [qsg_pkg::W-1:0]    inst_cond_in,
    input  wire logic [qsg_pkg::W-1:0]    phase1_cond_in,
    input  wire logic [qsg_pkg::W-1:0]    phase2_cond_in,
    input  wire logic [qsg_pkg::W-1:0]    phase3_cond_in,
    output logic                          questionable_summary_bit
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef logic [qsg_pkg::W-1:0] qsg_word_t;

    typedef struct packed {
        qsg_word_t                        qcond;
        qsg_word_t                        qevt;
        qsg_word_t                        qen;
        qsg_word_t                        qptr;
        qsg_word_t                        qntr;
        qsg_word_t                        icond;
        qsg_word_t                        ievt;
        qsg_word_t                        ien;
        qsg_word_t                        iptr;
        qsg_word_t                        intr;
        logic [3:1][qsg_pkg::W-1:0]       pcond;
        logic [3:1][qsg_pkg::W-1:0]       pevt;
        logic [3:1][qsg_pkg::W-1:0]       pptr;
        logic [3:1][qsg_pkg::W-1:0]       pntr;
        qsg_word_t                        rdata;
        logic                             summary;
    } qsg_state_t;

    qsg_state_t                           state_ff;
    qsg_state_t                           nxt_state;
    logic [3:1][qsg_pkg::W-1:0]           phase_in;
    logic                                 cmd_wr;
    logic                                 do_cls;
    logic                                 do_preset;
    logic                                 do_reset;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // New events OR into the held value after any clear, so an edge in the
    // clearing cycle survives.
    function automatic qsg_word_t evt_next(
        input qsg_word_t evt,
        input logic      clr,
        input qsg_word_t cur,
        input qsg_word_t nxt,
        input qsg_word_t ptr,
        input qsg_word_t ntr
    );
        qsg_word_t held;
        held = clr ? qsg_pkg::ZERO : evt;                                  // [R03]
        return held | (nxt & ~cur & ptr)                                   // [R05] [R06] [R07]
                    | (cur & ~nxt & ntr);                                  // [R04] [R06] [R07]
    endfunction

    // Phase index 1..3 within a four-word bank; index 0 is unmapped.
    function automatic logic in_bank(
        input logic [qsg_pkg::AW-1:0] a,
        input logic [qsg_pkg::AW-1:0] base
    );
        return (a[qsg_pkg::AW-1:2] == base[qsg_pkg::AW-1:2]) && (a[1:0] != 2'h0);
    endfunction

    assign phase_in[1] = phase1_cond_in;
    assign phase_in[2] = phase2_cond_in;
    assign phase_in[3] = phase3_cond_in;

    assign cmd_wr    = wr && (addr == qsg_pkg::A_CMD);
    assign do_cls    = cmd_wr && wdata[qsg_pkg::CMD_CLS];
    assign do_preset = cmd_wr && wdata[qsg_pkg::CMD_PRESET];
    assign do_reset  = cmd_wr && wdata[qsg_pkg::CMD_RESET];

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [1:0] ph;
        logic       rd_q;
        logic       rd_i;
        nxt_state = state_ff;
        ph        = addr[1:0];
        rd_q      = rd && (addr == qsg_pkg::A_QEVT);
        rd_i      = rd && (addr == qsg_pkg::A_IEVT);

        // Conditions follow their sources; a reset command drops them for one
        // cycle, and any still present return on the next.
        nxt_state.qcond = do_reset ? qsg_pkg::ZERO : questionable_summary_bit_cond_in;          // [R13] [R14]
        nxt_state.icond = do_reset ? qsg_pkg::ZERO : inst_cond_in;          // [R12] [R13] [R14]

        // Events: reset command edges pass through the filters like any other
        nxt_state.qevt = evt_next(state_ff.qevt, do_cls || rd_q, state_ff.qcond,
                                  nxt_state.qcond, state_ff.qptr, state_ff.qntr); // [R11] [R20]
        nxt_state.ievt = evt_next(state_ff.ievt, do_cls || rd_i, state_ff.icond,
                                  nxt_state.icond, state_ff.iptr, state_ff.intr); // [R10] [R11] [R16]

        for (int p = 1; p <= qsg_pkg::NPH; p++) begin
            nxt_state.pcond[p] = do_reset ? qsg_pkg::ZERO : phase_in[p];    // [R13] [R14]
            nxt_state.pevt[p]  = evt_next(state_ff.pevt[p],
                                          do_cls || (rd && in_bank(addr, qsg_pkg::A_PEVT)
                                                     && (int'(ph) == p)),
                                          state_ff.pcond[p], nxt_state.pcond[p],
                                          state_ff.pptr[p], state_ff.pntr[p]); // [R17] [R18]
        end

        // Writable masks and filters; event and condition words ignore writes
        if (wr && addr == qsg_pkg::A_QEN) begin
            nxt_state.qen = wdata;                                          // [R02]
        end else if (wr && addr == qsg_pkg::A_QPTR) begin
            nxt_state.qptr = wdata;
        end else if (wr && addr == qsg_pkg::A_QNTR) begin
            nxt_state.qntr = wdata;
        end else if (wr && addr == qsg_pkg::A_IEN) begin
            nxt_state.ien = wdata;
        end else if (wr && addr == qsg_pkg::A_IPTR) begin
            nxt_state.iptr = wdata;
        end else if (wr && addr == qsg_pkg::A_INTR) begin
            nxt_state.intr = wdata;
        end else if (wr && in_bank(addr, qsg_pkg::A_PPTR)) begin
            nxt_state.pptr[ph] = wdata;
        end else if (wr && in_bank(addr, qsg_pkg::A_PNTR)) begin
            nxt_state.pntr[ph] = wdata;
        end

        if (do_preset) begin
            nxt_state.qen  = qsg_pkg::ZERO;                                 // [R08]
            nxt_state.ien  = qsg_pkg::ZERO;
            nxt_state.qptr = qsg_pkg::ALL_ONES;                             // [R19]
            nxt_state.iptr = qsg_pkg::ALL_ONES;
            nxt_state.qntr = qsg_pkg::ZERO;
            nxt_state.intr = qsg_pkg::ZERO;
            for (int p = 1; p <= qsg_pkg::NPH; p++) begin
                nxt_state.pptr[p] = qsg_pkg::ALL_ONES;                      // [R19]
                nxt_state.pntr[p] = qsg_pkg::ZERO;
            end
        end

        // Read data returns the value before any clear-on-read takes effect
        nxt_state.rdata = qsg_pkg::ZERO;
        if (rd) begin
            if (addr == qsg_pkg::A_QCOND) begin
                nxt_state.rdata = state_ff.qcond;                           // [R09]
            end else if (addr == qsg_pkg::A_QEVT) begin
                nxt_state.rdata = state_ff.qevt;
            end else if (addr == qsg_pkg::A_QEN) begin
                nxt_state.rdata = state_ff.qen;
            end else if (addr == qsg_pkg::A_QPTR) begin
                nxt_state.rdata = state_ff.qptr;
            end else if (addr == qsg_pkg::A_QNTR) begin
                nxt_state.rdata = state_ff.qntr;
            end else if (addr == qsg_pkg::A_ICOND) begin
                nxt_state.rdata = state_ff.icond;                           // [R12]
            end else if (addr == qsg_pkg::A_IEVT) begin
                nxt_state.rdata = state_ff.ievt;
            end else if (addr == qsg_pkg::A_IEN) begin
                nxt_state.rdata = state_ff.ien;
            end else if (addr == qsg_pkg::A_IPTR) begin
                nxt_state.rdata = state_ff.iptr;
            end else if (addr == qsg_pkg::A_INTR) begin
                nxt_state.rdata = state_ff.intr;
            end else if (in_bank(addr, qsg_pkg::A_PEVT)) begin
                nxt_state.rdata = state_ff.pevt[ph];                        // [R17]
            end else if (in_bank(addr, qsg_pkg::A_PCOND)) begin
                nxt_state.rdata = state_ff.pcond[ph];
            end else if (in_bank(addr, qsg_pkg::A_PPTR)) begin
                nxt_state.rdata = state_ff.pptr[ph];
            end else if (in_bank(addr, qsg_pkg::A_PNTR)) begin
                nxt_state.rdata = state_ff.pntr[ph];
            end
        end

        // Summary follows the new event and enable words on the same edge
        nxt_state.summary = |(nxt_state.qevt & nxt_state.qen)              // [R01]
                          | |(nxt_state.ievt & nxt_state.ien);             // [R15]
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            state_ff <= '0;                                                 // [R02] [R21]
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign rdata                    = state_ff.rdata;
    assign questionable_summary_bit = state_ff.summary;

endmodule

`default_nettype wire

// file: tb/qsg_status_props.sv
// Port-level assertions for the questionable status block
`timescale 1ns/1ps
`default_nettype none
module qsg_status_props (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic [7:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] rdata,
    input wire logic [15:0] questionable_summary_bit_cond_in,
    input wire logic [15:0] inst_cond_in,
    input wire logic        questionable_summary_bit
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    chk_idle_rdata_zero: assert property (!rd |=> rdata == 16'h0000)
        else $error("read data not zero after an idle cycle");
    chk_qcond_live: assert property (rd && addr == qsg_pkg::A_QCOND && $stable(questionable_summary_bit_cond_in) && !$past(wr)
        && !$past(rst) |=> rdata == $past(questionable_summary_bit_cond_in)) else $error("condition read is not the live input");
    chk_icond_live: assert property (rd && addr == qsg_pkg::A_ICOND && $stable(inst_cond_in) && !$past(wr)
        && !$past(rst) |=> rdata == $past(inst_cond_in)) else $error("instrument condition read is stale");
    chk_unmapped_zero: assert property (rd && (addr == 8'h0a || addr == qsg_pkg::A_PEVT)
        |=> rdata == 16'h0000) else $error("unmapped read returned data");
    chk_enable_readback: assert property (wr && addr == qsg_pkg::A_QEN ##1 !wr
        ##1 rd && addr == qsg_pkg::A_QEN |=> rdata == $past(wdata, 3)) else $error("enable mask read back differs");
    chk_event_read_clears: assert property ((rd && addr == qsg_pkg::A_QEVT && $stable(questionable_summary_bit_cond_in)
        && !$past(wr)) ##1 (!wr && $stable(questionable_summary_bit_cond_in)) ##1 (rd && addr == qsg_pkg::A_QEVT) |=> rdata == 16'h0000)
        else $error("event register not cleared by read");
    chk_preset_summary: assert property (wr && addr == qsg_pkg::A_CMD && wdata[qsg_pkg::CMD_PRESET]
        |=> !questionable_summary_bit) else $error("summary high after preset");
    chk_clear_summary: assert property (wr && addr == qsg_pkg::A_CMD && wdata[qsg_pkg::CMD_CLS] && !$past(wr)
        && !wdata[qsg_pkg::CMD_RESET] && $stable(questionable_summary_bit_cond_in) && $stable(inst_cond_in) |=> !questionable_summary_bit)
        else $error("summary high after clear-status");
    chk_summary_holds: assert property (!wr && !rd && !$past(wr) && $stable(questionable_summary_bit_cond_in)
        && $stable(inst_cond_in) |=> $stable(questionable_summary_bit)) else $error("summary moved with no cause");
endmodule
bind qsg_status qsg_status_props qsg_status_props_i (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .questionable_summary_bit_cond_in(questionable_summary_bit_cond_in), .inst_cond_in(inst_cond_in),
    .questionable_summary_bit(questionable_summary_bit));
`default_nettype wire

// file: tb/qsg_status_test.sv
// Register-level self-checking bench for the questionable status block
`timescale 1ns/1ps
`default_nettype none
module qsg_status_test;
    logic             clock       = 1'b0;
    logic             rst         = 1'b1;
    logic [7:0]       addr        = 8'h00;
    logic [15:0]      wdata       = 16'h0000;
    logic             wr          = 1'b0;
    logic             rd          = 1'b0;
    logic [15:0]      qc          = 16'h0000;
    logic [15:0]      ic          = 16'h0000;
    logic [2:0][15:0] pc          = '0;
    logic [15:0]      rdata;
    logic             summ;
    int               err_total   = 0;
    int               comparisons = 0;
    logic [7:0]       regs [12]   = '{8'h02, 8'h03, 8'h04, 8'h07, 8'h08, 8'h09,
                                      8'h19, 8'h1a, 8'h1b, 8'h1d, 8'h1e, 8'h1f};

    always #2.5 clock = ~clock;

    qsg_status qsg_status_i (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .questionable_summary_bit_cond_in(qc), .inst_cond_in(ic), .phase1_cond_in(pc[0]), .phase2_cond_in(pc[1]),
        .phase3_cond_in(pc[2]), .questionable_summary_bit(summ));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic chk_sum(input logic e);
        check({15'h0000, summ}, {15'h0000, e});
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clock);
        wr    <= 1'b0;
    endtask
    // Data stand only in the cycle after the read edge, so look just past it
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clock);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd   <= 1'b0;
        #1;
        check(rdata, exp);
    endtask
    // Condition change lands on the read edge, so a new event meets the clear
    task automatic rd_chk_q(input logic [7:0] a, input logic [15:0] exp, input logic [15:0] v);
        @(posedge clock);
        rd   <= 1'b1;
        addr <= a;
        qc   <= v;
        @(posedge clock);
        rd   <= 1'b0;
        #1;
        check(rdata, exp);
    endtask
    task automatic set_q(input logic [15:0] v);
        @(posedge clock);
        qc <= v;
    endtask
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Hang guard: the whole run needs far fewer cycles than this
    initial begin
        #100000;
        err_total++;
        give_verdict();
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        foreach (regs[i]) begin
            rd_chk(regs[i], 16'h0000);
            wr_reg(regs[i], 16'h008c);
            rd_chk(regs[i], 16'h008c);
        end
        wr_reg(qsg_pkg::A_QPTR, 16'h0005);
        wr_reg(qsg_pkg::A_QNTR, 16'h0006);
        wr_reg(qsg_pkg::A_QEN, 16'h0000);
        set_q(16'h000f);
        rd_chk(qsg_pkg::A_QCOND, 16'h000f);
        rd_chk(qsg_pkg::A_QEVT, 16'h0005);
        rd_chk(qsg_pkg::A_QEVT, 16'h0000);
        set_q(16'h0000);
        rd_chk(qsg_pkg::A_QCOND, 16'h0000);
        rd_chk(qsg_pkg::A_QEVT, 16'h0006);
        wr_reg(qsg_pkg::A_QEN, 16'h0001);
        set_q(16'h0001);
        @(posedge clock);
        #1;
        chk_sum(1'b1);
        wr_reg(qsg_pkg::A_CMD, 16'h0001);
        #1;
        chk_sum(1'b0);
        rd_chk(qsg_pkg::A_QEN, 16'h0001);
        rd_chk(qsg_pkg::A_QEVT, 16'h0000);
        wr_reg(qsg_pkg::A_IPTR, 16'h8000);
        wr_reg(qsg_pkg::A_INTR, 16'h0000);
        wr_reg(qsg_pkg::A_IEN, 16'h8000);
        @(posedge clock);
        ic <= 16'h8001;
        rd_chk(qsg_pkg::A_ICOND, 16'h8001);
        chk_sum(1'b1);
        rd_chk(qsg_pkg::A_IEVT, 16'h8000);
        chk_sum(1'b0);
        rd_chk(qsg_pkg::A_IEVT, 16'h0000);
        wr_reg(qsg_pkg::A_CMD, 16'h0002);
        foreach (regs[i]) begin
            rd_chk(regs[i], (regs[i] inside {8'h03, 8'h08, 8'h19, 8'h1a, 8'h1b}) ? 16'hffff : 16'h0000);
        end
        wr_reg(qsg_pkg::A_CMD, 16'h0004);
        rd_chk(qsg_pkg::A_QCOND, 16'h0001);
        rd_chk(qsg_pkg::A_QEVT, 16'h0001);
        wr_reg(qsg_pkg::A_QCOND, 16'hffff);
        rd_chk(qsg_pkg::A_QCOND, 16'h0001);
        rd_chk_q(qsg_pkg::A_QEVT, 16'h0000, 16'h0003);
        rd_chk(qsg_pkg::A_QEVT, 16'h0002);
        @(posedge clock);
        pc[0] <= 16'h0010;
        pc[1] <= 16'h0020;
        pc[2] <= 16'h0040;
        rd_chk(8'h12, 16'h0020);
        rd_chk(8'h11, 16'h0010);
        rd_chk(8'h13, 16'h0040);
        rd_chk(8'h12, 16'h0000);
        rd_chk(8'h13, 16'h0000);
        rd_chk(8'h16, 16'h0020);
        rd_chk(8'h10, 16'h0000);
        rd_chk(8'h0a, 16'h0000);
        // Second reset mid-run: filters loaded by preset must fall back to zero
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd_chk(qsg_pkg::A_QPTR, 16'h0000);
        chk_sum(1'b0);
        give_verdict();
    end
endmodule
`default_nettype wire
